// ==== logic/safcs_pkg.sv ====
/*
 * Constants for the second address filter and CSMA-CA statistics block:
 * register indices, field positions, reset values, timing counts, FSM codes.
 * Assumes a 100 MHz baseband clock and a 32-bit APB register port.
 */
package safcs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_BOP_TOTAL  = 8'hd4;
  localparam logic [7:0]  IDX_CCA_TOTAL  = 8'hd6;
  localparam logic [7:0]  IDX_FILT_CTL   = 8'hdf;
  localparam logic [7:0]  IDX_PAN_ID     = 8'he0;
  localparam logic [7:0]  IDX_SHORT_ADDR = 8'he2;
  localparam logic [7:0]  IDX_EXT_W0     = 8'he4;
  localparam logic [7:0]  IDX_EXT_W1     = 8'he6;
  localparam logic [7:0]  IDX_EXT_W2     = 8'he8;
  localparam logic [7:0]  IDX_EXT_W3     = 8'hea;
  localparam logic [7:0]  IDX_TIMEOUT    = 8'hec;
  localparam int unsigned APB_AW         = 10;
  // Control byte fields
  localparam int unsigned CTL_COORD_BIT  = 0;
  localparam int unsigned CTL_PEND_BIT   = 1;
  localparam int unsigned CTL_MON1_BIT   = 2;
  localparam int unsigned CTL_MON2_BIT   = 3;
  // Widths
  localparam int unsigned BOP_W          = 12;
  localparam int unsigned CCA_W          = 8;
  localparam int unsigned TMO_W          = 12;
  // Reset values
  localparam logic [1:0]  RST_FILT_CTL   = 2'h0;
  localparam logic [15:0] RST_PAN_ID     = 16'hffff;
  localparam logic [15:0] RST_SHORT_ADDR = 16'hffff;
  localparam logic [15:0] RST_EXT_WORD   = 16'h0000;
  localparam logic [11:0] RST_TIMEOUT    = 12'h7d0;
  localparam logic [15:0] BCAST_ID       = 16'hffff;
  // Destination address modes
  localparam logic [1:0]  DST_NONE       = 2'h0;
  localparam logic [1:0]  DST_SHORT      = 2'h2;
  localparam logic [1:0]  DST_EXT        = 2'h3;
  // Timeout step of 1 us in clock cycles
  localparam int unsigned TMO_STEP_NS    = 1000;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TMO_STEP_CYC   = TMO_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W        = 7;

  typedef enum logic [1:0] {
    TMO_IDLE = 2'b01,
    TMO_WAIT = 2'b10
  } safcs_tmo_state_t;
endpackage : safcs_pkg

// ==== logic/safcs_frame_if.sv ====
/*
 * Received frame header fields passed from the top to the matcher.
 * Assumes fields are valid in the cycle the top samples the match result.
 */
`timescale 1ns/1ns
`default_nettype none
interface safcs_frame_if;
  logic [1:0]  version;
  logic        is_beacon;
  logic        dst_pan_present;
  logic [1:0]  dst_mode;
  logic [15:0] dst_pan;
  logic [15:0] dst_short;
  logic [63:0] dst_ext;
  logic [15:0] src_pan;
  logic [15:0] first_pan;
  logic        primary_coord_select;
  modport src (output version, is_beacon, dst_pan_present, dst_mode, dst_pan,
               dst_short, dst_ext, src_pan, first_pan, primary_coord_select);
  modport match (input version, is_beacon, dst_pan_present, dst_mode, dst_pan,
                 dst_short, dst_ext, src_pan, first_pan, primary_coord_select);
endinterface : safcs_frame_if
`default_nettype wire

// ==== logic/safcs_sat_counter.sv ====
/*
 * Saturating event counter for the CSMA-CA statistics totals.
 * Assumes one increment pulse per event, synchronous to clk_in.
 */
`timescale 1ns/1ns
`default_nettype none
module safcs_sat_counter #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             inc_in,
  output logic [WIDTH-1:0]      count_out
);
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("Counter width out of range");
  end

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              at_max = &count_reg;

  assign count_next = (inc_in && !at_max) ? count_reg + 1'b1 : count_reg;
  assign count_out  = count_reg;

  always_ff @(posedge clk_in) begin
    if (reset_in) count_reg <= '0;
    else count_reg <= count_next;
  end

  AST_CNT_INC: assert property (@(posedge clk_in) disable iff (reset_in)
    inc_in && !at_max |=> count_reg == $past(count_reg) + 1'b1)
    else $error("Counter missed an event");
  AST_CNT_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
    at_max |=> at_max)
    else $error("Counter wrapped past its maximum");
endmodule : safcs_sat_counter
`default_nettype wire

// ==== logic/safcs_addr_match.sv ====
/*
 * Second address match for one received frame header.
 * Assumes header fields are stable while the result is sampled.
 */
`timescale 1ns/1ns
`default_nettype none
module safcs_addr_match (
  safcs_frame_if.match        frame,
  input  wire logic [15:0]    pan_id_in,
  input  wire logic [15:0]    short_addr_in,
  input  wire logic [63:0]    ext_addr_in,
  input  wire logic           coord_select_in,
  output logic                hit_out
);
  wire pan_ok   = frame.dst_pan == pan_id_in || frame.dst_pan == safcs_pkg::BCAST_ID;
  wire short_ok = frame.dst_mode == safcs_pkg::DST_SHORT &&
                  (frame.dst_short == short_addr_in ||
                   frame.dst_short == safcs_pkg::BCAST_ID);
  wire ext_ok   = frame.dst_mode == safcs_pkg::DST_EXT && frame.dst_ext == ext_addr_in;
  wire src_ok   = frame.src_pan == pan_id_in || frame.src_pan == frame.first_pan ||
                  pan_id_in == safcs_pkg::BCAST_ID ||
                  frame.first_pan == safcs_pkg::BCAST_ID;
  wire beacon_ok = coord_select_in && frame.version <= 2'h1 && frame.is_beacon &&
                   !frame.dst_pan_present && frame.dst_mode == safcs_pkg::DST_NONE &&
                   src_ok && !frame.primary_coord_select;

  assign hit_out = (frame.dst_pan_present && pan_ok && (short_ok || ext_ok)) || beacon_ok;
endmodule : safcs_addr_match
`default_nettype wire

// ==== logic/safcs_top.sv ====
/*
 * Second address filter extension and CSMA-CA statistics, with the
 * acknowledgement wait timeout, behind a zero-wait APB slave.
 * Assumes header fields and event pulses come from the receive path,
 * synchronous to clk_in; the first filter supplies its match and PAN ID.
 */
`timescale 1ns/1ns
`default_nettype none

// Function
// - Count CSMA-CA backoff periods into a read-only 12-bit total, reset zero.
// - Count CSMA-CA clear channel assessments into read-only 8-bit total, reset zero.
// - Coordinator option bit makes second address act as coordinator address.
// - Acknowledgement pending bit takes second pending setting for second-address frames.
// - Two read-only match monitors, read from the bank chosen by bank select.
// - Monitors are meaningless while address extension is disabled.
// - Coordinator condition accepts qualifying beacon frames without destination fields.
// - Control byte: coordinator bit 0, pending bit 1, monitors bits 2, 3 read-only.
// - Second PAN identifier setting, 16 bits, resets to all ones.
// - Second short address setting, 16 bits, resets to all ones.
// - Second extended address in four 16-bit words, each resetting to zero.
// - Extended address words map highest word to bits 63 to 48, downward.
// - Auto receive timeout fires when no PHR starts within programmed microseconds.
// - Timeout setting resets to 2000 microseconds.
module safcs_top #(
  parameter int unsigned STEP_CYCLES = safcs_pkg::TMO_STEP_CYC
) (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [safcs_pkg::APB_AW-1:0]  paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  output logic      [31:0]                   prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  input  wire logic                          backoff_pulse_in,
  input  wire logic                          cca_pulse_in,
  input  wire logic                          frame_valid_in,
  input  wire logic [1:0]                    frame_version_in,
  input  wire logic                          frame_is_beacon_in,
  input  wire logic                          dst_pan_present_in,
  input  wire logic [1:0]                    dst_addr_mode_in,
  input  wire logic [15:0]                   dst_pan_in,
  input  wire logic [15:0]                   dst_short_in,
  input  wire logic [63:0]                   dst_ext_in,
  input  wire logic [15:0]                   src_pan_in,
  input  wire logic [15:0]                   first_pan_in,
  input  wire logic                          primary_coord_select_in,
  input  wire logic                          first_match_in,
  input  wire logic                          frame_bank_in,
  input  wire logic                          address_ext_enable_in,
  input  wire logic                          rx_bank_select_in,
  input  wire logic                          auto_rx_timeout_enable_in,
  input  wire logic                          ack_wait_start_in,
  input  wire logic                          phr_start_in,
  output logic                               second_match_out,
  output logic                               ack_pending_out,
  output logic                               ack_timeout_out
);
  if (STEP_CYCLES < 1 || STEP_CYCLES > (1 << safcs_pkg::PRESC_W)) begin : g_bad_step
    $error("STEP_CYCLES does not fit the prescaler");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [1:0]                    ctl_reg;
  logic [15:0]                   pan_id_reg;
  logic [15:0]                   short_addr_reg;
  logic [15:0]                   ext_word_reg [4];
  logic [safcs_pkg::TMO_W-1:0]   timeout_reg;
  logic [31:0]                   prdata_reg;
  logic                          pslverr_reg;
  logic [1:0]                    mon1_bank_reg;
  logic [1:0]                    mon2_bank_reg;
  logic                          second_match_reg;
  logic                          ack_pending_reg;
  logic [safcs_pkg::BOP_W-1:0]   bop_total;
  logic [safcs_pkg::CCA_W-1:0]   cca_total;
  logic                          second_hit;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire       setup     = psel_in && !penable_in;
  wire       access    = psel_in && penable_in;
  wire       aligned   = paddr_in[1:0] == 2'b00;
  wire [7:0] idx       = paddr_in[safcs_pkg::APB_AW-1:2];
  wire       sel_bop   = aligned && idx == safcs_pkg::IDX_BOP_TOTAL;
  wire       sel_cca   = aligned && idx == safcs_pkg::IDX_CCA_TOTAL;
  wire       sel_ctl   = aligned && idx == safcs_pkg::IDX_FILT_CTL;
  wire       sel_pan   = aligned && idx == safcs_pkg::IDX_PAN_ID;
  wire       sel_short = aligned && idx == safcs_pkg::IDX_SHORT_ADDR;
  wire       sel_tmo   = aligned && idx == safcs_pkg::IDX_TIMEOUT;
  wire [3:0] sel_ext;
  assign sel_ext[0] = aligned && idx == safcs_pkg::IDX_EXT_W0;
  assign sel_ext[1] = aligned && idx == safcs_pkg::IDX_EXT_W1;
  assign sel_ext[2] = aligned && idx == safcs_pkg::IDX_EXT_W2;
  assign sel_ext[3] = aligned && idx == safcs_pkg::IDX_EXT_W3;
  wire       mapped    = sel_bop || sel_cca || sel_ctl || sel_pan || sel_short ||
                         sel_tmo || (|sel_ext);
  wire       wr        = access && pwrite_in;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  wire        mon1_rd = address_ext_enable_in && mon1_bank_reg[rx_bank_select_in];
  wire        mon2_rd = address_ext_enable_in && mon2_bank_reg[rx_bank_select_in];
  wire [7:0]  ctl_rd  = {4'h0, mon2_rd, mon1_rd, ctl_reg};
  wire [63:0] ext_addr = {ext_word_reg[3], ext_word_reg[2],
                          ext_word_reg[1], ext_word_reg[0]};
  wire [31:0] rd_mux =
      sel_bop    ? {20'h0_0000, bop_total} :
      sel_cca    ? {24'h00_0000, cca_total} :
      sel_ctl    ? {24'h00_0000, ctl_rd} :
      sel_pan    ? {16'h0000, pan_id_reg} :
      sel_short  ? {16'h0000, short_addr_reg} :
      sel_ext[0] ? {16'h0000, ext_word_reg[0]} :
      sel_ext[1] ? {16'h0000, ext_word_reg[1]} :
      sel_ext[2] ? {16'h0000, ext_word_reg[2]} :
      sel_ext[3] ? {16'h0000, ext_word_reg[3]} :
      sel_tmo    ? {20'h0_0000, timeout_reg} : 32'h0000_0000;

  // Answer is captured at setup so the data leaves a flip-flop
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg  <= rd_mux;
      pslverr_reg <= !mapped;
    end
  end

  assign prdata_out  = prdata_reg;
  assign pready_out  = 1'b1;
  assign pslverr_out = access && pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Writable settings
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctl_reg        <= safcs_pkg::RST_FILT_CTL;
      pan_id_reg     <= safcs_pkg::RST_PAN_ID;
      short_addr_reg <= safcs_pkg::RST_SHORT_ADDR;
      timeout_reg    <= safcs_pkg::RST_TIMEOUT;
    end else if (wr) begin
      if (sel_ctl) ctl_reg <= pwdata_in[safcs_pkg::CTL_PEND_BIT:safcs_pkg::CTL_COORD_BIT];
      if (sel_pan) pan_id_reg <= pwdata_in[15:0];
      if (sel_short) short_addr_reg <= pwdata_in[15:0];
      if (sel_tmo) timeout_reg <= pwdata_in[safcs_pkg::TMO_W-1:0];
    end
  end

  for (genvar w = 0; w < 4; w++) begin : g_ext_word
    always_ff @(posedge clk_in) begin
      if (reset_in) ext_word_reg[w] <= safcs_pkg::RST_EXT_WORD;
      else if (wr && sel_ext[w]) ext_word_reg[w] <= pwdata_in[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Statistics counters
  safcs_sat_counter #(.WIDTH(safcs_pkg::BOP_W)) u_bop_total (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .inc_in    (backoff_pulse_in),
    .count_out (bop_total)
  );

  safcs_sat_counter #(.WIDTH(safcs_pkg::CCA_W)) u_cca_total (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .inc_in    (cca_pulse_in),
    .count_out (cca_total)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Second address match and monitor banks
  safcs_frame_if frame_bus ();
  assign frame_bus.version              = frame_version_in;
  assign frame_bus.is_beacon            = frame_is_beacon_in;
  assign frame_bus.dst_pan_present      = dst_pan_present_in;
  assign frame_bus.dst_mode             = dst_addr_mode_in;
  assign frame_bus.dst_pan              = dst_pan_in;
  assign frame_bus.dst_short            = dst_short_in;
  assign frame_bus.dst_ext              = dst_ext_in;
  assign frame_bus.src_pan              = src_pan_in;
  assign frame_bus.first_pan            = first_pan_in;
  assign frame_bus.primary_coord_select = primary_coord_select_in;

  safcs_addr_match u_match (
    .frame           (frame_bus),
    .pan_id_in       (pan_id_reg),
    .short_addr_in   (short_addr_reg),
    .ext_addr_in     (ext_addr),
    .coord_select_in (ctl_reg[safcs_pkg::CTL_COORD_BIT]),
    .hit_out         (second_hit)
  );

  for (genvar b = 0; b < 2; b++) begin : g_bank
    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        mon1_bank_reg[b] <= 1'b0;
        mon2_bank_reg[b] <= 1'b0;
      end else if (frame_valid_in && frame_bank_in == 1'(b)) begin
        mon1_bank_reg[b] <= first_match_in;
        mon2_bank_reg[b] <= second_hit;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      second_match_reg <= 1'b0;
      ack_pending_reg  <= 1'b0;
    end else if (frame_valid_in) begin
      second_match_reg <= second_hit;
      ack_pending_reg  <= second_hit && ctl_reg[safcs_pkg::CTL_PEND_BIT];
    end
  end

  assign second_match_out = second_match_reg;
  assign ack_pending_out  = ack_pending_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledgement wait timeout
  safcs_pkg::safcs_tmo_state_t    tmo_state_reg;
  safcs_pkg::safcs_tmo_state_t    tmo_state_next;
  logic [safcs_pkg::PRESC_W-1:0]  presc_reg;
  logic [safcs_pkg::TMO_W-1:0]    us_cnt_reg;
  logic                           timeout_reg_out;

  wire                            step_done = presc_reg == STEP_CYCLES[safcs_pkg::PRESC_W-1:0] - 1'b1;
  wire [safcs_pkg::TMO_W:0]       us_after  = {1'b0, us_cnt_reg} + 1'b1;
  wire                            expire    = step_done && us_after >= {1'b0, timeout_reg};

  always_comb begin
    tmo_state_next = tmo_state_reg;
    unique case (tmo_state_reg)
      safcs_pkg::TMO_IDLE: begin
        if (ack_wait_start_in && auto_rx_timeout_enable_in) tmo_state_next = safcs_pkg::TMO_WAIT;
      end
      safcs_pkg::TMO_WAIT: begin
        if (phr_start_in || !auto_rx_timeout_enable_in || expire) begin
          tmo_state_next = safcs_pkg::TMO_IDLE;
        end
      end
      default: tmo_state_next = safcs_pkg::TMO_IDLE;
    endcase
  end

  wire waiting = tmo_state_reg == safcs_pkg::TMO_WAIT;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tmo_state_reg   <= safcs_pkg::TMO_IDLE;
      presc_reg       <= '0;
      us_cnt_reg      <= '0;
      timeout_reg_out <= 1'b0;
    end else begin
      tmo_state_reg   <= tmo_state_next;
      presc_reg       <= (!waiting || step_done) ? '0 : presc_reg + 1'b1;
      us_cnt_reg      <= !waiting ? '0 : (step_done ? us_after[safcs_pkg::TMO_W-1:0] : us_cnt_reg);
      timeout_reg_out <= waiting && !phr_start_in && auto_rx_timeout_enable_in && expire;
    end
  end

  assign ack_timeout_out = timeout_reg_out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [19:0] wait_cyc_reg;
  always_ff @(posedge clk_in) begin
    if (reset_in || !waiting) wait_cyc_reg <= '0;
    else wait_cyc_reg <= wait_cyc_reg + 1'b1;
  end
  logic [19:0] wait_cyc_seen;
  always_ff @(posedge clk_in) begin
    if (reset_in) wait_cyc_seen <= '0;
    else if (waiting) wait_cyc_seen <= wait_cyc_reg + 1'b1;
  end

  AST_TIMEOUT_LEN: assert property (@(posedge clk_in) disable iff (reset_in)
    ack_timeout_out && timeout_reg != '0 |->
      wait_cyc_seen == 20'(timeout_reg) * 20'(STEP_CYCLES))
    else $error("Timeout fired at the wrong time");
  AST_RESET_VALUES: assert property (@(posedge clk_in)
    reset_in |=> timeout_reg == 12'h7d0 && pan_id_reg == 16'hffff &&
                 short_addr_reg == 16'hffff && ext_addr == 64'h0 && ctl_reg == 2'h0)
    else $error("Settings not at their reset values");
  AST_PEND_BIT: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_valid_in |=> ack_pending_out == ($past(second_hit) && $past(ctl_reg[1])))
    else $error("Pending bit not from the second pending setting");
  AST_MON_RO: assert property (@(posedge clk_in) disable iff (reset_in)
    wr && sel_ctl && !frame_valid_in |=> $stable(mon1_bank_reg) && $stable(mon2_bank_reg))
    else $error("Monitor bits changed by a write");
  AST_MON_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
    setup && sel_ctl && !address_ext_enable_in |=> prdata_out[3:2] == 2'b00)
    else $error("Monitors visible while extension disabled");
  AST_MON_BANK: assert property (@(posedge clk_in) disable iff (reset_in)
    frame_valid_in ##1 !frame_valid_in
    ##1 setup && sel_ctl && address_ext_enable_in && !frame_valid_in &&
        rx_bank_select_in == $past(frame_bank_in, 2)
    |=> prdata_out[3] == $past(second_hit, 3))
    else $error("Second monitor does not show the selected bank");
  AST_BEACON: assert property (@(posedge clk_in) disable iff (reset_in)
    ctl_reg[0] && frame_is_beacon_in && frame_version_in == 2'b01 && !dst_pan_present_in &&
    dst_addr_mode_in == 2'b00 && !primary_coord_select_in && src_pan_in == pan_id_reg
    |-> second_hit)
    else $error("Qualifying beacon rejected");
  AST_EXT_MAP: assert property (@(posedge clk_in) disable iff (reset_in)
    wr && sel_ext[3] |=> ext_addr[63:48] == $past(pwdata_in[15:0]))
    else $error("Extended address word mapping wrong");
  AST_PHR_STOPS: assert property (@(posedge clk_in) disable iff (reset_in)
    waiting && phr_start_in |=> !ack_timeout_out && !waiting)
    else $error("Timeout kept after a PHR start");
  AST_IDLE_QUIET: assert property (@(posedge clk_in) disable iff (reset_in)
    !waiting |=> !ack_timeout_out)
    else $error("Timeout outside an acknowledgement wait");
  AST_PEND_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
    !second_match_out |-> !ack_pending_out)
    else $error("Pending bit set for a missed frame");
  AST_CTL_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
    wr && sel_ctl |=> ctl_reg == $past(pwdata_in[1:0]))
    else $error("Control bits not taken from the write");
  AST_CCA_RO: assert property (@(posedge clk_in) disable iff (reset_in)
    wr && sel_cca && !cca_pulse_in |=> $stable(cca_total))
    else $error("Write reached the assessment total");

  COV_TIMEOUT: cover property (@(posedge clk_in) disable iff (reset_in) ack_timeout_out);
  COV_BEACON: cover property (@(posedge clk_in) disable iff (reset_in)
    frame_valid_in && second_hit && ctl_reg[0] && !dst_pan_present_in);
  COV_BOP_SAT: cover property (@(posedge clk_in) disable iff (reset_in)
    &bop_total && backoff_pulse_in);
  COV_MON_OFF: cover property (@(posedge clk_in) disable iff (reset_in)
    setup && sel_ctl && !address_ext_enable_in);
  COV_PHR_STOP: cover property (@(posedge clk_in) disable iff (reset_in)
    waiting && phr_start_in);
endmodule : safcs_top
`default_nettype wire

// ==== test/safcs_node_model.sv ====
/* Remote node model: presents one received frame header per send call.
   Assumes calls come from the bench's clocked sequence. */
`timescale 1ns/1ns
`default_nettype none
module safcs_node_model (
  input  wire logic   clk_in,
  output logic        valid_out,
  output logic        beacon_out,
  output logic        dpp_out,
  output logic [1:0]  ver_out,
  output logic [1:0]  mode_out,
  output logic [15:0] dpan_out,
  output logic [15:0] dshort_out,
  output logic [15:0] span_out,
  output logic [63:0] dext_out
);
  initial valid_out = 1'b0;
  initial {beacon_out, dpp_out, ver_out, mode_out, dpan_out, dshort_out, span_out, dext_out} = '0;
  // Header scrambled once it is no longer valid
  task automatic send(input logic b, input logic [1:0] v, m, input logic [15:0] dp, ds, sp,
                      input logic [63:0] de);
    @(posedge clk_in);
    valid_out <= 1'b1;
    {beacon_out, dpp_out, ver_out, mode_out, dpan_out, dshort_out, span_out, dext_out} <=
      {b, m != safcs_pkg::DST_NONE, v, m, dp, ds, sp, de};
    @(posedge clk_in);
    valid_out <= 1'b0;
    {beacon_out, dpp_out, ver_out, mode_out, dpan_out, dshort_out, span_out, dext_out} <=
      ~{b, m != safcs_pkg::DST_NONE, v, m, dp, ds, sp, de};
  endtask : send
endmodule : safcs_node_model
`default_nettype wire

// ==== test/tb_safcs_top.sv ====
/* Self-checking bench for safcs_top: APB master, counters, frames, timeout.
   Assumes a 100 MHz clock and a timeout step shortened to 4 cycles. */
`timescale 1ns/1ns
`default_nettype none
module tb_safcs_top;
  localparam int unsigned STEP = 4;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, bo = 0, cca = 0;
  logic        fm = 0, bank = 0, st = 0, phr = 0, prdy, perr, er, hit, pnd, tmo, fv, fb, fdp;
  logic        rsel = 0, aen = 1, pcs = 0, aut = 1;
  logic [9:0]  pa = '0;
  logic [31:0] pwd = '0, prd, rd;
  logic [95:0] wv;
  logic [1:0]  fver, fmode;
  logic [15:0] fdpan, fdsh, fspan;
  logic [63:0] fdext;
  logic [7:0]  idx [10] = '{8'hd4, 8'hd6, 8'hdf, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec};
  logic [15:0] rv [10] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'hffff, 16'h0000,
                           16'h0000, 16'h0000, 16'h0000, 16'h07d0};
  int          bad_count = 0, comparisons = 0, k, n;
  always #5 clk = ~clk;
  safcs_node_model node (.clk_in(clk), .valid_out(fv), .beacon_out(fb), .dpp_out(fdp),
    .ver_out(fver), .mode_out(fmode), .dpan_out(fdpan), .dshort_out(fdsh), .span_out(fspan),
    .dext_out(fdext));
  safcs_top #(.STEP_CYCLES(STEP)) dut (.clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .backoff_pulse_in(bo), .cca_pulse_in(cca),
    .frame_valid_in(fv), .frame_version_in(fver), .frame_is_beacon_in(fb),
    .dst_pan_present_in(fdp), .dst_addr_mode_in(fmode), .dst_pan_in(fdpan), .dst_short_in(fdsh),
    .dst_ext_in(fdext), .src_pan_in(fspan), .first_pan_in(16'h0000),
    .primary_coord_select_in(pcs), .first_match_in(fm), .frame_bank_in(bank),
    .address_ext_enable_in(aen), .rx_bank_select_in(rsel), .auto_rx_timeout_enable_in(aut),
    .ack_wait_start_in(st), .phr_start_in(phr), .second_match_out(hit), .ack_pending_out(pnd),
    .ack_timeout_out(tmo));
  task automatic test_done;
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, i, 2'b00, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 1, 0);
      test_done();
    end
    rd = prd;
    er = perr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task automatic frame(input logic b, input logic [1:0] m, input logic [15:0] dp, ds, sp,
                       input logic [63:0] de, input logic e);
    node.send(b, 2'h1, m, dp, ds, sp, de);
    #1;
    chk("match", e, hit);
    chk("pending", e & rd[1], pnd);
  endtask : frame
  initial begin
    void'($urandom(32'hbbe7));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1, 8'hd6, 32'h0000_00ff);
    apb(0, 8'h01, 32'h0000_0000);
    chk("slverr", 1, er);
    for (k = 0; k < 10; k++) begin
      apb(0, idx[k], 32'h0000_0000);
      chk("reset value", rv[k], rd);
    end
    k = $urandom_range(200, 1);
    {bo, cca} <= 2'b11;
    repeat (k) @(posedge clk);
    {bo, cca} <= 2'b00;
    apb(0, 8'hd4, 32'h0000_0000);
    chk("backoff total", k, rd);
    apb(0, 8'hd6, 32'h0000_0000);
    chk("cca total", k, rd);
    {bo, cca} <= 2'b11;
    repeat (4200) @(posedge clk);
    {bo, cca} <= 2'b00;
    apb(0, 8'hd4, 32'h0000_0000);
    chk("backoff total", 32'h0000_0fff, rd);
    apb(0, 8'hd6, 32'h0000_0000);
    chk("cca total", 32'h0000_00ff, rd);
    wv = {$urandom, 16'($urandom), 16'h0000, 16'h7fff & 16'($urandom), 16'($urandom)};
    for (k = 0; k < 6; k++) apb(1, 8'he0 + 8'(2 * k), {16'h0000, wv[16 * k +: 16]});
    for (k = 0; k < 6; k++) begin
      apb(0, 8'he0 + 8'(2 * k), 32'h0000_0000);
      chk("address word", wv[16 * k +: 16], rd);
    end
    apb(1, 8'hdf, 32'h0000_000f);
    apb(0, 8'hdf, 32'h0000_0000);
    chk("control", 32'h0000_0003, rd);
    n = $urandom;
    {fm, bank, rsel} <= {n[1], n[0], n[0]};
    frame(0, 2'h2, wv[15:0], wv[31:16], 16'h1234, 64'h0, 1);
    frame(0, 2'h2, wv[15:0], wv[31:16] ^ 16'h0001, 16'h1234, 64'h0, 0);
    frame(0, 2'h3, wv[15:0], 16'h0000, 16'h1234, wv[95:32], 1);
    frame(0, 2'h3, wv[15:0], 16'h0000, 16'h1234, wv[95:32] ^ 64'h0001_0000_0000_0000, 0);
    frame(1, 2'h0, 16'h0000, 16'h0000, wv[15:0], 64'h0, 1);
    apb(0, 8'hdf, 32'h0000_0000);
    chk("monitors", {fm, 1'b1, 2'b11}, {rd[2], rd[3], rd[1:0]});
    rsel <= ~bank;
    apb(0, 8'hdf, 32'h0000_0000);
    chk("other bank", 2'b00, rd[3:2]);
    {rsel, aen} <= {bank, 1'b0};
    apb(0, 8'hdf, 32'h0000_0000);
    chk("monitors off", 2'b00, rd[3:2]);
    {aen, pcs} <= 2'b11;
    frame(1, 2'h0, 16'h0000, 16'h0000, wv[15:0], 64'h0, 0);
    apb(1, 8'hdf, 32'h0000_0002);
    pcs <= 1'b0;
    frame(1, 2'h0, 16'h0000, 16'h0000, wv[15:0], 64'h0, 0);
    apb(1, 8'hec, 32'h0000_0003);
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      {st, aut} <= {1'b1, k != 2};
      n = 0;
      do begin
        @(posedge clk);
        n++;
        st <= 1'b0;
        phr <= (k == 1 && n == 2);
        #1;
      end while (tmo !== 1'b1 && n < 30);
      chk("timeout cycles", k ? 30 : 3 * STEP + 1, n);
    end
    test_done();
  end
endmodule : tb_safcs_top
`default_nettype wire
